// ---- shared/emif_core_map.svh ----
`ifndef EMIF_CORE_MAP_SVH
`define EMIF_CORE_MAP_SVH

// Address layout: four spaces of 4M bytes each
`define ADDR_W        24
`define DATA_W        32
`define SPACE_HI      23
`define SPACE_LO      22
`define NUM_SPACES    4
`define NUM_SRC       6

// Reset values of the pin-facing outputs
`define GRANT_N_RST   1'b0
`define DRIVE_EN_RST  1'b0
`define CS_N_IDLE     4'hF

`endif

// ---- shared/emif_core_pkg.sv ----
package emif_core_pkg;
`include "emif_core_map.svh"

    typedef logic [2:0] memory_type_field_t;

    // Memory type codes; all others reserved
    localparam memory_type_field_t MT_ASYNC8  = 3'h0;
    localparam memory_type_field_t MT_ASYNC16 = 3'h1;
    localparam memory_type_field_t MT_ASYNC32 = 3'h2;
    localparam memory_type_field_t MT_SDRAM   = 3'h3;
    localparam memory_type_field_t MT_SBSRAM  = 3'h4;

    // Request sources in falling priority
    localparam int SRC_E   = 0;
    localparam int SRC_F   = 1;
    localparam int SRC_D   = 2;
    localparam int SRC_C   = 3;
    localparam int SRC_P   = 4;
    localparam int SRC_DMA = 5;

    typedef struct packed {
        logic                valid;
        logic                write;
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  data;
    } cpu_req_t;

    typedef struct packed {
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  data;
    } post_entry_t;

    typedef struct packed {
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  data;
        logic                write;
        logic [1:0]          space;
        memory_type_field_t              memory_type_field;
        logic                rom;
        logic                hold_merged;
    } ext_acc_t;

    typedef enum {
        S_SHARE, S_RESUME, S_IDLE, S_DEAD, S_ACCESS, S_REFRESH, S_STOP, S_SLEEP
    } state_t;

endpackage : emif_core_pkg

// ---- hw/post_slots.sv ----
`timescale 1ns/10ps
module post_slots #(
    parameter int WIDTH = 56,
    parameter int DEPTH = 2
) (
    // Clock
    input  wire logic                     i_clk,
    // Write port
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
    input  wire logic [WIDTH-1:0]         i_wr_data,
    // Read port, registered
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
    output logic      [WIDTH-1:0]         o_rd_data
);
    if (DEPTH < 2 || WIDTH < 1) begin : g_size_check
        $error("post_slots: DEPTH must be >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem[i_rd_addr];
    end
endmodule : post_slots

// ---- hw/emif_core.sv ----
`timescale 1ns/10ps
//
// Behaviour
// - Four chip-enable spaces, space 0 lowest, each up to 4M bytes.
// - Part of space 3 goes to internal ROM when the ROM map bit is set.
// - Async and burst SRAM spaces get their chip select low during access.
// - SDRAM arrangements may span two or four spaces; here each SDRAM space drives only its own chip select.
// - Three-bit memory type per space: async 8/16/32, SDRAM, burst SRAM.
// - Writes to an 8-bit async space are never performed, except to the internal ROM part of space 3.
// - Space or direction change inserts one dead cycle, all selects high.
// - That dead cycle doubles as the async extended hold cycle.
// - Share request is synchronised and has top priority.
// - On share request, finish the current access then stop.
// - Outputs released first, grant driven low afterwards.
// - No refresh during share; owed refresh comes first after release.
// - Block bit makes share requests ignored.
// - Without posting, acknowledge only after the external access, except DMA writes and dropped 8-bit writes.
// - With posting, acknowledge bus E and F writes at once and store them.
// - Two posting entries, allocated in arrival order.
// - Write bus E beats write bus F for a posting entry.
// - One global bit enables posting; clear disables it.
// - DMA writes are acknowledged early, without posting entries.
// - Idle request drains posted entries; idle ignores refresh and share.
// - Reset sits in share state, grant low; leave when no request.
// - Fixed priority: share, urgent refresh, posted entry, E, F, D, C, P, DMA, trickle.
module emif_core
#(
    parameter int                 POST_DEPTH = 2,
    parameter logic [`ADDR_W-1:0] ROM_BASE   = 24'hFF0000
) (
    // Clock and reset
    input  wire logic                           i_clk,
    input  wire logic                           i_rstn,
    // Bus share pins
    input  wire logic                           i_share_req_n,
    output logic                                o_bus_share_grant_n,
    output logic                                o_drive_en,
    // Configuration
    input  wire emif_core_pkg::memory_type_field_t          i_memory_type_field [`NUM_SPACES],
    input  wire logic                           i_share_request_block,
    input  wire logic                           i_post_write_enable,
    input  wire logic                           i_rom_map_select,
    // Power domain idle
    input  wire logic                           i_idle_req,
    output logic                                o_idle_ack,
    // CPU and DMA requests
    input  wire emif_core_pkg::cpu_req_t        i_req [`NUM_SRC],
    output logic [`NUM_SRC-1:0]                 o_ack,
    // Refresh requests
    input  wire logic                           i_refresh_urgent,
    input  wire logic                           i_refresh_trickle,
    output logic                                o_refresh_go,
    // Protocol engine side
    output emif_core_pkg::ext_acc_t             o_acc,
    output logic                                o_acc_start,
    input  wire logic                           i_acc_done,
    // Chip selects
    output logic                                o_chip_select0_n,
    output logic                                o_chip_select1_n,
    output logic                                o_chip_select2_n,
    output logic                                o_chip_select3_n
);
    import emif_core_pkg::*;

    localparam int PW = $clog2(POST_DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(POST_DEPTH);

    if (POST_DEPTH != 2) begin : g_depth_check
        $error("emif_core: POST_DEPTH must be 2");
    end

    function automatic logic [3:0] first_one(input logic [8:0] v);
        logic [3:0] idx;
        idx = 4'hF;
        for (int i = 8; i >= 0; i--) begin
            if (v[i]) idx = 4'(i);
        end
        return idx;
    endfunction : first_one

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and share pin synchroniser

    logic rst_meta;
    logic rstn_int;
    logic share_meta;
    logic share_sync_n;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rstn_int <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rstn_int <= rst_meta;
        end
    end

    always_ff @(posedge i_clk or negedge rstn_int) begin
        if (!rstn_int) begin
            share_meta   <= 1'b1;
            share_sync_n <= 1'b1;
        end else begin
            share_meta   <= i_share_req_n;
            share_sync_n <= share_meta;
        end
    end

    wire share_act = ~share_sync_n & ~i_share_request_block;

    ////////////////////////////////////////////////////////////////////////////
    // Posting entries

    state_t             state;
    state_t             next_state;
    logic [PW-1:0]      head;
    logic [PW-1:0]      tail;
    logic [PW:0]        post_cnt;
    logic [PW:0]        cnt_seen;
    post_entry_t        slot_q;
    logic               pop;

    wire [`NUM_SRC-1:0] elig;
    for (genvar g = 0; g < `NUM_SRC; g++) begin : g_elig
        assign elig[g] = i_req[g].valid & ~o_ack[g];
    end

    wire       posting   = i_post_write_enable;
    wire [1:0] post_cand = {elig[SRC_F], elig[SRC_E]} & {2{posting && post_cnt < FULL}};
    wire [3:0] post_win  = first_one({7'h00, post_cand});
    wire       push      = post_cand != 2'b00;
    wire       push_f    = post_win == 4'h1;
    wire [2:0] push_src  = push_f ? 3'(SRC_F) : 3'(SRC_E);

    post_slots #(
        .WIDTH ($bits(post_entry_t)),
        .DEPTH (POST_DEPTH)
    ) u_slots (
        .i_clk     (i_clk),
        .i_wr_en   (push),
        .i_wr_addr (tail),
        .i_wr_data ({i_req[push_src].addr, i_req[push_src].data}),
        .i_rd_addr (head),
        .o_rd_data (slot_q)
    );

    // Entry usable once its registered read data have settled
    wire slot_avail = (post_cnt != '0) && (cnt_seen != '0);

    always_ff @(posedge i_clk or negedge rstn_int) begin
        if (!rstn_int) begin
            head     <= '0;
            tail     <= '0;
            post_cnt <= '0;
            cnt_seen <= '0;
        end else begin
            head     <= pop ? head + 1'b1 : head;
            tail     <= push ? tail + 1'b1 : tail;
            post_cnt <= post_cnt + (PW+1)'(push) - (PW+1)'(pop);
            cnt_seen <= pop ? '0 : post_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration and space decode

    logic     refresh_owed;
    logic     have_last;
    logic     last_write;
    logic     ack_at_done;
    logic [1:0] last_space;
    logic [2:0] acc_src;
    ext_acc_t acc;

    wire       ref_urgent = i_refresh_urgent | refresh_owed;
    wire [8:0] cand = {i_refresh_trickle, elig[SRC_DMA], elig[SRC_P], elig[SRC_C],
                       elig[SRC_D], elig[SRC_F] & ~posting, elig[SRC_E] & ~posting,
                       slot_avail, ref_urgent};
    wire [3:0] win       = first_one(cand);
    wire       from_slot = win == 4'h1;
    wire       is_cpu    = win >= 4'h2 && win <= 4'h7;
    wire [2:0] win_src   = is_cpu ? 3'(win - 4'h2) : 3'(SRC_E);
    wire       sel_write = from_slot | i_req[win_src].write;
    wire [`ADDR_W-1:0] sel_addr = from_slot ? slot_q.addr : i_req[win_src].addr;
    wire [`DATA_W-1:0] sel_data = from_slot ? slot_q.data : i_req[win_src].data;
    wire [1:0] sel_space = sel_addr[`SPACE_HI:`SPACE_LO];
    wire memory_type_field_t sel_memory_type_field = i_memory_type_field[sel_space];
    wire sel_rom  = i_rom_map_select && sel_space == 2'h3 && sel_addr >= ROM_BASE;
    wire sel_drop = sel_write && sel_memory_type_field == MT_ASYNC8 && !sel_rom;
    wire need_dead = have_last && (sel_space != last_space || sel_write != last_write);
    wire sel_async = sel_memory_type_field <= MT_ASYNC32;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    logic [`NUM_SRC-1:0] next_ack;
    logic                next_start;
    logic                next_refresh_go;
    logic                issue;
    logic                next_ack_at_done;
    ext_acc_t            next_acc;

    always_comb begin
        next_state       = state;
        next_ack         = '0;
        next_start       = 1'b0;
        next_refresh_go  = 1'b0;
        next_acc         = acc;
        next_ack_at_done = ack_at_done;
        pop              = 1'b0;
        issue            = 1'b0;
        if (push) next_ack[push_src] = 1'b1;
        unique case (state)
            S_SHARE:  if (!share_act) next_state = S_RESUME;
            S_RESUME: next_state = S_IDLE;
            S_STOP:   next_state = S_SHARE;
            S_SLEEP:  if (!i_idle_req) next_state = S_IDLE;
            S_DEAD: begin
                next_state = S_ACCESS;
                next_start = 1'b1;
            end
            S_ACCESS: if (i_acc_done) begin
                next_state = S_IDLE;
                if (ack_at_done) next_ack[acc_src] = 1'b1;
            end
            S_REFRESH: if (i_acc_done) next_state = S_IDLE;
            S_IDLE: begin
                if (share_act) begin
                    next_state = S_STOP;
                end else if (i_idle_req && post_cnt == '0) begin
                    next_state = S_SLEEP;
                end else if (win == 4'h0 || win == 4'h8) begin
                    next_state      = S_REFRESH;
                    next_refresh_go = 1'b1;
                end else if (win != 4'hF) begin
                    pop = from_slot;
                    if (sel_drop) begin
                        if (is_cpu) next_ack[win_src] = 1'b1;
                    end else begin
                        issue = 1'b1;
                        next_acc = '{addr: sel_addr, data: sel_data, write: sel_write,
                                     space: sel_space, memory_type_field: sel_memory_type_field, rom: sel_rom,
                                     hold_merged: need_dead && sel_async};
                        next_ack_at_done = is_cpu && !(win_src == 3'(SRC_DMA) && sel_write);
                        if (is_cpu && win_src == 3'(SRC_DMA) && sel_write) begin
                            next_ack[win_src] = 1'b1;
                        end
                        next_state = need_dead ? S_DEAD : S_ACCESS;
                        next_start = !need_dead;
                    end
                end
            end
        endcase
    end

    // Selects low only in access; SDRAM uses its own space's select
    wire       next_in_acc = next_state == S_ACCESS && !next_acc.rom;
    wire [3:0] next_cs_n = next_in_acc ? ~(4'h1 << next_acc.space) : `CS_N_IDLE;
    wire       next_grant_n = next_state != S_SHARE;
    wire       next_drive = next_state != S_SHARE && next_state != S_STOP;

    always_ff @(posedge i_clk or negedge rstn_int) begin
        if (!rstn_int) begin
            state       <= S_SHARE;
            o_bus_share_grant_n <= `GRANT_N_RST;
            o_drive_en  <= `DRIVE_EN_RST;
            {o_chip_select3_n, o_chip_select2_n, o_chip_select1_n, o_chip_select0_n} <= `CS_N_IDLE;
            o_ack       <= '0;
            o_acc_start <= 1'b0;
            o_refresh_go <= 1'b0;
            o_idle_ack  <= 1'b0;
            acc         <= '0;
            acc_src     <= '0;
            ack_at_done <= 1'b0;
        end else begin
            state       <= next_state;
            o_bus_share_grant_n <= next_grant_n;
            o_drive_en  <= next_drive;
            {o_chip_select3_n, o_chip_select2_n, o_chip_select1_n, o_chip_select0_n} <= next_cs_n;
            o_ack       <= next_ack;
            o_acc_start <= next_start;
            o_refresh_go <= next_refresh_go;
            o_idle_ack  <= next_state == S_SLEEP;
            acc         <= next_acc;
            acc_src     <= issue ? win_src : acc_src;
            ack_at_done <= next_ack_at_done;
        end
    end

    assign o_acc = acc;

    always_ff @(posedge i_clk or negedge rstn_int) begin
        if (!rstn_int) begin
            have_last    <= 1'b0;
            last_space   <= '0;
            last_write   <= 1'b0;
            refresh_owed <= 1'b0;
        end else begin
            have_last  <= have_last | issue;
            last_space <= issue ? sel_space : last_space;
            last_write <= issue ? sel_write : last_write;
            if (state == S_SHARE && (i_refresh_urgent || i_refresh_trickle)) begin
                refresh_owed <= 1'b1;
            end else if (next_refresh_go && win == 4'h0) begin
                refresh_owed <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rstn_int);

    sequence release_then_grant_s;
        !o_drive_en ##1 !o_bus_share_grant_n;
    endsequence

    stop_then_grant_a: assert property ($fell(o_bus_share_grant_n) |->
        $past(!o_drive_en) && !o_drive_en) else $error("grant before outputs released");
    idle_stop_a: assert property (state == S_IDLE && share_act |=>
        release_then_grant_s) else $error("share stop sequence wrong");
    dead_select_a: assert property (state == S_DEAD |->
        {o_chip_select3_n, o_chip_select2_n, o_chip_select1_n, o_chip_select0_n}
        == 4'hF ##1 o_acc_start) else $error("dead cycle selects or start wrong");
    no_byte_write_a: assert property (o_acc_start && o_acc.write |->
        o_acc.memory_type_field != MT_ASYNC8 || o_acc.rom) else $error("write to 8-bit space");
    block_share_a: assert property (state == S_IDLE && i_share_request_block |=>
        state != S_STOP) else $error("blocked share request honoured");
    e_over_f_a: assert property (elig[SRC_E] && elig[SRC_F] && posting
        && post_cnt < FULL |=> o_ack[SRC_E] && !o_ack[SRC_F]) else $error("F won over E");
    share_quiet_a: assert property (!o_bus_share_grant_n |-> !o_refresh_go
        && !o_acc_start) else $error("activity while shared");
    sleep_quiet_a: assert property (state == S_SLEEP |=> o_bus_share_grant_n
        && !o_refresh_go) else $error("activity while idle");
    urgent_first_a: assert property (state == S_IDLE && !share_act && !i_idle_req
        && i_refresh_urgent |=> o_refresh_go) else $error("urgent refresh not first");
    late_ack_a: assert property (state == S_ACCESS && i_acc_done && ack_at_done
        |=> o_ack[acc_src]) else $error("missing ack after access");
    resume_order_a: assert property ($rose(o_bus_share_grant_n) |-> o_drive_en
        && !o_acc_start && !o_refresh_go) else $error("resumed before release");
endmodule : emif_core

// ---- testbench/acc_engine_model.sv ----
`timescale 1ns/10ps
module acc_engine_model (
    // Clock
    input  wire logic i_clk,
    // Starts from the core
    input  wire logic i_acc_start,
    input  wire logic i_refresh_go,
    // Completion pulse
    output logic      o_acc_done
);
    ////////////////////////////////////////////////////////////////////
    // Protocol engine: answers each access or refresh after 1 to 4 cycles
    initial begin
        o_acc_done = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_acc_start === 1'b1 || i_refresh_go === 1'b1) begin
                repeat ($urandom_range(4, 1)) @(posedge i_clk);
                #1 o_acc_done = 1'b1;
                @(posedge i_clk);
                #1 o_acc_done = 1'b0;
            end
        end
    end
endmodule : acc_engine_model

// ---- testbench/test_emif_core.sv ----
`timescale 1ns/10ps
`include "emif_core_map.svh"
module test_emif_core;
    import emif_core_pkg::*;
    localparam logic [23:0] ROM_AT = 24'hFF0000;
    logic i_clk, i_rstn, share_n, grant_n, drive_en, block, post_en, rom_sel;
    logic idle_req, idle_ack, ref_urg, ref_tri, ref_go, acc_start, acc_done;
    logic [5:0] ack;
    logic [3:0] cs_n;
    logic [1:0] prev_sp;
    logic       prev_wr, prev_ok;
    memory_type_field_t     mt [4];
    cpu_req_t   rq [6];
    ext_acc_t   acc, e;
    ext_acc_t   exp_q [$];
    time        ack_at [6];
    int fails, samples_checked, done_cnt, go_cnt, start_cnt, g, s, dn, d2, d3, d4;

    emif_core #(.POST_DEPTH(2), .ROM_BASE(ROM_AT)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_share_req_n(share_n),
        .o_bus_share_grant_n(grant_n), .o_drive_en(drive_en),
        .i_memory_type_field(mt), .i_share_request_block(block),
        .i_post_write_enable(post_en), .i_rom_map_select(rom_sel),
        .i_idle_req(idle_req), .o_idle_ack(idle_ack), .i_req(rq), .o_ack(ack),
        .i_refresh_urgent(ref_urg), .i_refresh_trickle(ref_tri), .o_refresh_go(ref_go),
        .o_acc(acc), .o_acc_start(acc_start), .i_acc_done(acc_done),
        .o_chip_select0_n(cs_n[0]), .o_chip_select1_n(cs_n[1]),
        .o_chip_select2_n(cs_n[2]), .o_chip_select3_n(cs_n[3]));

    acc_engine_model engine (.i_clk(i_clk), .i_acc_start(acc_start),
        .i_refresh_go(ref_go), .o_acc_done(acc_done));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic wait_on(ref logic sig, input logic val, input int lim);
        int n;
        n = 0;
        do begin @(posedge i_clk); n++; end while (sig !== val && n < lim);
        check(sig, val);
        #1;
    endtask : wait_on

    function automatic logic [23:0] rnd(input logic [1:0] sp);
        return {sp, 22'($urandom)};
    endfunction : rnd

    // Queue an expected external access; space from top address bits
    task automatic put(input logic wr, input logic [23:0] a, input logic [31:0] d);
        ext_acc_t x;
        x = '0;
        x.addr = a;
        x.data = d;
        x.write = wr;
        x.space = a[`SPACE_HI:`SPACE_LO];
        x.memory_type_field = mt[x.space];
        x.rom = rom_sel && x.space == 2'h3 && a >= ROM_AT;
        exp_q.push_back(x);
    endtask : put

    // Hold the request until acked; returns completions seen meanwhile
    task automatic op(input int src, input logic wr, input logic [23:0] a, output int dones);
        int n, d0;
        logic [31:0] d;
        d = $urandom;
        d0 = done_cnt;
        if (!(wr && mt[a[23:22]] == MT_ASYNC8)) put(wr, a, d);
        rq[src] = {1'b1, wr, a, d};
        n = 0;
        do begin @(posedge i_clk); n++; end while (ack[src] !== 1'b1 && n < 60);
        check(n < 60, 1'b1);
        ack_at[src] = $time;
        #1 rq[src].valid = 1'b0;
        dones = done_cnt - d0;
        // Let an edge pass before the same source is driven again
        @(posedge i_clk);
        #1;
    endtask : op

    ////////////////////////////////////////////////////////////////////
    // Reference model of every external access start
    always @(posedge i_clk) begin
        if (acc_done === 1'b1) done_cnt++;
        if (ref_go === 1'b1) go_cnt++;
        if (grant_n === 1'b0) check({drive_en, ref_go}, 2'b00);
        if (acc_start === 1'b1) begin
            start_cnt++;
            check(exp_q.size() > 0, 1'b1);
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                check({acc.addr, acc.write, acc.space, acc.memory_type_field, acc.rom},
                      {e.addr, e.write, e.space, e.memory_type_field, e.rom});
                if (e.write) check(acc.data, e.data);
                if (e.rom) check(cs_n, 4'hF);
                else if (e.memory_type_field != MT_SDRAM) check(cs_n, 4'(~(4'h1 << e.space)));
                if (prev_ok && !e.rom && e.memory_type_field <= MT_ASYNC32)
                    check(acc.hold_merged, prev_sp != e.space || prev_wr != e.write);
                prev_ok = 1'b1;
                prev_sp = e.space;
                prev_wr = e.write;
            end
        end
    end

    initial begin
        #200000;
        fails++;
        results();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        {i_rstn, block, post_en, rom_sel, idle_req, ref_urg, ref_tri, prev_ok} = '0;
        share_n = 1'b1;
        foreach (rq[i]) rq[i] = '0;
        mt = '{MT_ASYNC8, MT_ASYNC16, MT_ASYNC32, MT_ASYNC32};
        void'($urandom(32'h6F51E26A));
        repeat (5) @(posedge i_clk);
        #1 check({grant_n, drive_en, cs_n}, 6'b001111);
        i_rstn = 1'b1;
        wait_on(grant_n, 1'b1, 20);
        check(drive_en, 1'b1);
        for (int c = 0; c <= 4; c++) begin
            mt[1] = memory_type_field_t'(c);
            op(SRC_D, 1'b0, rnd(2'h1), dn);
            check(dn > 0, 1'b1);
        end
        mt[1] = MT_ASYNC16;
        op(SRC_D, 1'b0, rnd(2'h2), dn);
        op(SRC_E, 1'b1, rnd(2'h2), dn);
        check(dn > 0, 1'b1);
        op(SRC_E, 1'b1, rnd(2'h2), dn);
        op(SRC_C, 1'b0, rnd(2'h3), dn);
        s = start_cnt;
        op(SRC_E, 1'b1, rnd(2'h0), dn);
        repeat (6) @(posedge i_clk);
        #1 check(start_cnt, s);
        op(SRC_D, 1'b0, rnd(2'h0), dn);
        op(SRC_DMA, 1'b1, rnd(2'h1), dn);
        check(dn, 0);
        fork
            op(SRC_D, 1'b0, rnd(2'h1), dn);
            op(SRC_C, 1'b0, rnd(2'h3), d2);
            op(SRC_P, 1'b0, rnd(2'h2), d3);
            op(SRC_DMA, 1'b0, rnd(2'h1), d4);
        join
        check(ack_at[SRC_D] < ack_at[SRC_C] && ack_at[SRC_C] < ack_at[SRC_P], 1'b1);
        post_en = 1'b1;
        fork
            op(SRC_E, 1'b1, rnd(2'h1), dn);
            op(SRC_F, 1'b1, rnd(2'h2), d2);
        join
        check({dn == 0, ack_at[SRC_E] < ack_at[SRC_F]}, 2'b11);
        op(SRC_E, 1'b1, rnd(2'h3), dn);
        op(SRC_D, 1'b0, rnd(2'h3), dn);
        post_en = 1'b0;
        block = 1'b1;
        share_n = 1'b0;
        repeat (12) @(posedge i_clk);
        #1 check(grant_n, 1'b1);
        block = 1'b0;
        wait_on(grant_n, 1'b0, 12);
        ref_tri = 1'b1;
        g = go_cnt;
        fork
            op(SRC_D, 1'b0, rnd(2'h1), dn);
            begin
                repeat (8) @(posedge i_clk);
                // External master keeps the request low while it owns the bus
                #1 share_n = 1'b1;
                check(go_cnt, g);
                do @(posedge i_clk); while (ref_go !== 1'b1 && acc_start !== 1'b1);
                check({ref_go, grant_n, drive_en}, 3'b111);
                #1 ref_tri = 1'b0;
            end
        join
        ref_urg = 1'b1;
        wait_on(ref_go, 1'b1, 20);
        ref_urg = 1'b0;
        idle_req = 1'b1;
        wait_on(idle_ack, 1'b1, 30);
        {share_n, ref_tri} = 2'b01;
        g = go_cnt;
        repeat (10) @(posedge i_clk);
        check({grant_n, go_cnt == g}, 2'b11);
        #1 {share_n, ref_tri} = 2'b10;
        repeat (4) @(posedge i_clk);
        #1 idle_req = 1'b0;
        rom_sel = 1'b1;
        op(SRC_D, 1'b0, ROM_AT + 24'h10, dn);
        rom_sel = 1'b0;
        op(SRC_D, 1'b0, ROM_AT + 24'h10, dn);
        repeat (20) @(posedge i_clk);
        check(exp_q.size(), 0);
        results();
    end
endmodule : test_emif_core
